// >>> hw/prit_clock_source.sv
// Divided clock source with falling edge detect.
// Assumes synchronous select; high-to-low switch yields one tick.
`timescale 1ns/100ps
module prit_clock_source
	import prit_pkg::*;
(
	// System
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     ce,
	// Core side
	prit_tick_if.src      tk
);
	logic [PRESC_W-1:0] presc;
	logic               level;
	logic               lastLevel;

	function automatic logic srcLevel(input logic [2:0] s, input logic [PRESC_W-1:0] p);
		case (s)
			3'h1:    srcLevel = p[TAP_1];
			3'h2:    srcLevel = p[TAP_2];
			3'h3:    srcLevel = p[TAP_3];
			3'h4:    srcLevel = p[TAP_4];
			3'h5:    srcLevel = p[TAP_5];
			3'h6:    srcLevel = p[TAP_6];
			3'h7:    srcLevel = p[TAP_7];
			default: srcLevel = 1'b0;
		endcase
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			presc <= '0;
		else if (ce)
			presc <= presc + 1'b1;
	end

	assign level = srcLevel(tk.sel, presc);

	// Selected level, so a switch high to low reads as a falling edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			lastLevel <= 1'b0;
		else if (ce)
			lastLevel <= level;
	end

	assign tk.tick = lastLevel & ~level;
endmodule

// >>> hw/prit_pkg.sv
// Constants and types for the pseudo-static RAM refresh / interval timer.
// Assumes one system clock; control bits arrive as plain ports.
package prit_pkg;
	localparam int COUNT_W         = 8;
	localparam int PRESC_W         = 12;
	localparam int CKS_W           = 3;
	// Prescaler tap per clock source select (0 = halted)
	localparam logic [3:0] TAP_1   = 4'h0;
	localparam logic [3:0] TAP_2   = 4'h2;
	localparam logic [3:0] TAP_3   = 4'h4;
	localparam logic [3:0] TAP_4   = 4'h6;
	localparam logic [3:0] TAP_5   = 4'h8;
	localparam logic [3:0] TAP_6   = 4'hA;
	localparam logic [3:0] TAP_7   = 4'hB;
	// Field positions of timer control/status
	localparam int TCS_FLAG_BIT    = 7;
	localparam int TCS_IE_BIT      = 6;
	localparam int TCS_CKS_LSB     = 3;
	localparam logic [COUNT_W-1:0] COUNT_RST   = 8'h00;
	localparam logic [COUNT_W-1:0] COMPARE_RST = 8'hFF;
	localparam logic [CKS_W-1:0]   CKS_RST     = 3'h0;
	// Refresh cycle length in states, same as the DRAM cycle
	localparam logic [2:0] REFRESH_STATES = 3'h4;
	// Wait states above this count as a greatly prolonged cycle
	localparam logic [7:0] LONG_WAIT_LIMIT = 8'h10;

	typedef enum logic [1:0] {
		PRIT_GRANT_EXT  = 2'h0,
		PRIT_GRANT_REF  = 2'h1,
		PRIT_GRANT_DMA  = 2'h2,
		PRIT_GRANT_CPU  = 2'h3
	} prit_grant_t;

	typedef enum logic [1:0] {
		PRIT_IDLE  = 2'h0,
		PRIT_CYCLE = 2'h1,
		PRIT_WAIT  = 2'h2
	} prit_ref_state_t;
endpackage

// >>> hw/prit_refresh_timer.sv
// Refresh controller / interval timer core for pseudo-static RAM.
// Assumes synchronous control inputs; writes are flagged in their T3 state.
// How it works
// - Refresh period comes from compare value and clock source select.
// - Refresh cycle lasts the same states as the DRAM cycle.
// - Grant order: external master, refresh, DMA, then CPU.
// - With area-3 wait enable set, waits stretch refresh cycles too.
// - Self-refresh standby entry drives chip select high, refresh strobe low.
// - Leaving standby returns refresh strobe high.
// - Standby: chip select high, read and write strobes floated with pseudo-static RAM enabled, strobe per mode.
// - Runs in sleep, stops in hardware standby; software standby clears counter.
// - Software standby also clears flag and interrupt enable.
// - Flag sets when counter leaves the matching value.
// - Clear during counter write wins; write is lost.
// - Write during increment wins; increment skipped.
// - Compare write suppresses a coinciding compare match.
// - Counter clocks on falling edges; high-to-low switch counts once.
// - Interrupt only while interrupt enable is set.
// - Clearing a memory enable may drive strobe and chip select low together.
// - No refresh while bus released, in standby, or in long waits.
// - Requests during bus release collapse into one held request.
// - During long waits only the first request is held.
// - First refresh request after reset or standby is skipped.
`timescale 1ns/100ps
module prit_refresh_timer
	import prit_pkg::*;
(
	// System
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               ce,
	// Power-down modes
	input  wire logic               softStandby,
	input  wire logic               hardStandby,
	// Configuration
	input  wire logic               pseudoStaticEnable,
	input  wire logic               dynamicRamEnable,
	input  wire logic               selfRefreshSelect,
	input  wire logic               area3WaitEnable,
	input  wire logic               waitRequest,
	// Counter and compare access, strobed in T3
	input  wire logic               counterWrite,
	input  wire logic               compareWrite,
	input  wire logic               controlWrite,
	input  wire logic [7:0]         writeData,
	input  wire logic               flagClear,
	// Bus requests
	input  wire logic               extMasterReq,
	input  wire logic               dmaReq,
	input  wire logic               cpuReq,
	input  wire logic               busReleased,
	// Status
	output logic [COUNT_W-1:0]      refreshCounter,
	output logic [COUNT_W-1:0]      refreshCompareValue,
	output logic [7:0]              timerControlStatus,
	output logic                    compareInterrupt,
	output logic [1:0]              busGrant,
	output logic                    refreshActive,
	// Pins
	output logic                    refreshStrobeN,
	output logic                    area3ChipSelectN,
	output logic                    readStrobeOe,
	output logic                    upperWriteStrobeOe,
	output logic                    lowerWriteStrobeOe
);
	prit_tick_if tk();

	logic [CKS_W-1:0] clockSourceSelect;
	logic             compareFlag;
	logic             compareInterruptEnable;
	logic             matchSeen;
	logic             firstSkipped;
	logic             refreshPending;
	logic [2:0]       stateCount;
	logic [7:0]       waitCount;
	logic             longWait;
	logic             run;
	logic             matchEvent;
	logic             memEnabled;
	logic             lastMemEnabled;
	logic             stbyDone;
	// Read, upper write, lower write output enables
	logic [2:0]       strobeOe;
	prit_ref_state_t  refState;
	prit_ref_state_t  next_refState;
	prit_grant_t      next_grant;

	prit_clock_source clockSource (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.tk  (tk)
	);

	assign tk.sel     = clockSourceSelect;
	// Hardware standby halts; sleep is not an input, so it keeps running
	assign run        = ce & ~hardStandby;
	assign memEnabled = pseudoStaticEnable | dynamicRamEnable;
	// Match fires as the counter leaves the matching value
	assign matchEvent = tk.tick & matchSeen & ~compareWrite;
	assign longWait   = waitCount > LONG_WAIT_LIMIT;

	// Control bits; software standby clears flag and enable only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clockSourceSelect      <= CKS_RST;
			compareInterruptEnable <= 1'b0;
		end else if (run) begin
			if (softStandby)
				compareInterruptEnable <= 1'b0;
			else if (controlWrite) begin
				clockSourceSelect      <= writeData[TCS_CKS_LSB +: CKS_W];
				compareInterruptEnable <= writeData[TCS_IE_BIT];
			end
		end
	end

	// Compare flag: set beats clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			compareFlag <= 1'b0;
		else if (run) begin
			if (softStandby)
				compareFlag <= 1'b0;
			else if (matchEvent)
				compareFlag <= 1'b1;
			else if (flagClear)
				compareFlag <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			refreshCompareValue <= COMPARE_RST;
		else if (run && compareWrite)
			refreshCompareValue <= writeData;
	end

	// Counter: clear beats write, write beats increment
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			refreshCounter <= COUNT_RST;
		else if (run) begin
			if (softStandby)
				refreshCounter <= COUNT_RST;
			else if (matchEvent)
				refreshCounter <= COUNT_RST;
			else if (counterWrite)
				refreshCounter <= writeData;
			else if (tk.tick)
				refreshCounter <= refreshCounter + 1'b1;
		end
	end

	// Value currently equals compare, held until the next counter clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			matchSeen <= 1'b0;
		else if (run) begin
			if (softStandby || matchEvent)
				matchSeen <= 1'b0;
			else
				matchSeen <= (counterWrite ? writeData : refreshCounter) == refreshCompareValue;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			compareInterrupt <= 1'b0;
		else if (run)
			compareInterrupt <= compareFlag & compareInterruptEnable & ~memEnabled;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			timerControlStatus <= 8'h00;
		else if (run) begin
			timerControlStatus <= 8'h00;
			timerControlStatus[TCS_FLAG_BIT] <= compareFlag;
			timerControlStatus[TCS_IE_BIT]   <= compareInterruptEnable;
			timerControlStatus[TCS_CKS_LSB +: CKS_W] <= clockSourceSelect;
		end
	end

	// Wait-state length of the current bus cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			waitCount <= 8'h00;
		else if (run) begin
			if (waitRequest && area3WaitEnable && !longWait)
				waitCount <= waitCount + 1'b1;
			else if (!waitRequest)
				waitCount <= 8'h00;
		end
	end

	// First request after reset or standby is dropped
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			firstSkipped <= 1'b0;
		else if (run) begin
			if (softStandby)
				firstSkipped <= 1'b0;
			else if (matchEvent && pseudoStaticEnable)
				firstSkipped <= 1'b1;
		end
	end

	// One held request, however many arrive while blocked
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			refreshPending <= 1'b0;
		else if (run) begin
			if (softStandby || !pseudoStaticEnable)
				refreshPending <= 1'b0;
			else if (matchEvent && firstSkipped)
				refreshPending <= 1'b1;
			else if (refState == PRIT_IDLE && next_refState == PRIT_CYCLE)
				refreshPending <= 1'b0;
		end
	end

	// Arbiter priority
	always_comb begin
		if (extMasterReq)
			next_grant = PRIT_GRANT_EXT;
		else if (refreshPending && !busReleased && !longWait && !softStandby)
			next_grant = PRIT_GRANT_REF;
		else if (dmaReq)
			next_grant = PRIT_GRANT_DMA;
		else
			next_grant = PRIT_GRANT_CPU;
	end

	always_comb begin
		next_refState = refState;
		case (refState)
			PRIT_IDLE: begin
				if (next_grant == PRIT_GRANT_REF && !waitRequest)
					next_refState = PRIT_CYCLE;
			end
			PRIT_CYCLE: begin
				if (stateCount == REFRESH_STATES - 3'h1)
					next_refState = (area3WaitEnable && waitRequest) ? PRIT_WAIT : PRIT_IDLE;
			end
			PRIT_WAIT: begin
				if (!waitRequest)
					next_refState = PRIT_IDLE;
			end
			default: next_refState = PRIT_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			refState <= PRIT_IDLE;
		else if (run)
			refState <= softStandby ? PRIT_IDLE : next_refState;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			stateCount <= 3'h0;
		else if (run) begin
			if (refState == PRIT_CYCLE)
				stateCount <= stateCount + 3'h1;
			else
				stateCount <= 3'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busGrant      <= PRIT_GRANT_CPU;
			refreshActive <= 1'b0;
		end else if (run) begin
			busGrant      <= (refState != PRIT_IDLE) ? PRIT_GRANT_REF : next_grant;
			refreshActive <= next_refState != PRIT_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			lastMemEnabled <= 1'b0;
		else if (run)
			lastMemEnabled <= memEnabled;
	end

	// Standby with pseudo-static RAM attached releases the bus strobes
	function automatic logic strobesFloat(input logic sby, input logic psram);
		strobesFloat = sby & psram;
	endfunction

	assign stbyDone = strobesFloat(softStandby, pseudoStaticEnable) & selfRefreshSelect;

	// One enable flop per strobe pin, all released together
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gStrobeOe
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					strobeOe[g] <= 1'b1;
				else if (run)
					strobeOe[g] <= ~strobesFloat(softStandby, pseudoStaticEnable);
			end
		end
	endgenerate

	assign readStrobeOe       = strobeOe[0];
	assign upperWriteStrobeOe = strobeOe[1];
	assign lowerWriteStrobeOe = strobeOe[2];

	// Pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refreshStrobeN     <= 1'b1;
			area3ChipSelectN   <= 1'b1;
		end else if (run) begin
			if (softStandby) begin
				area3ChipSelectN <= 1'b1;
				refreshStrobeN   <= ~stbyDone;
			end else if (lastMemEnabled && !memEnabled) begin
				area3ChipSelectN <= 1'b0;
				refreshStrobeN   <= 1'b0;
			end else begin
				area3ChipSelectN <= 1'b1;
				refreshStrobeN   <= ~(next_refState != PRIT_IDLE);
			end
		end
	end
endmodule

// >>> hw/prit_tick_if.sv
// Carrier between the timer core and its clock divider.
// Assumes both ends share clk.
`timescale 1ns/100ps
interface prit_tick_if;
	logic [2:0] sel;
	logic       tick;
	modport src (input sel, output tick);
	modport dst (output sel, input tick);
endinterface

// >>> tb/prit_psram_model.sv
// Pseudo-static RAM seen from its refresh pins.
// Assumes active-low strobe and chip select from the core.
`timescale 1ns/100ps
module prit_psram_model (
	// System
	input  wire logic clk,
	input  wire logic rst,
	// Pins
	input  wire logic refreshStrobeN,
	input  wire logic area3ChipSelectN,
	// Observation
	output int        refreshCount,
	output int        pulseLen
);
	int run;
	// Strobe low with chip select high is a refresh
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			refreshCount <= 0;
			pulseLen <= 0;
			run <= 0;
		end else if (!refreshStrobeN && area3ChipSelectN) begin
			run <= run + 1;
		end else if (run != 0) begin
			refreshCount <= refreshCount + 1;
			pulseLen <= run;
			run <= 0;
		end
	end
endmodule

// >>> tb/prit_refresh_timer_monitor.sv
// Checker on the refresh timer ports.
// Bound to the core by the bench; one clock domain.
`timescale 1ns/100ps
module prit_refresh_timer_monitor
	import prit_pkg::*;
(
	// System
	input wire logic               clk,
	input wire logic               rst,
	// Controls
	input wire logic               softStandby,
	input wire logic               pseudoStaticEnable,
	input wire logic               selfRefreshSelect,
	input wire logic               counterWrite,
	input wire logic               compareWrite,
	input wire logic [7:0]         writeData,
	input wire logic               extMasterReq,
	input wire logic               busReleased,
	// Results
	input wire logic [COUNT_W-1:0] refreshCounter,
	input wire logic [COUNT_W-1:0] refreshCompareValue,
	input wire logic [7:0]         timerControlStatus,
	input wire logic               compareInterrupt,
	input wire logic [1:0]         busGrant,
	input wire logic               refreshActive,
	input wire logic               refreshStrobeN,
	input wire logic               area3ChipSelectN,
	input wire logic               readStrobeOe,
	input wire logic               upperWriteStrobeOe,
	input wire logic               lowerWriteStrobeOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_cnt_wr;
		counterWrite && !softStandby && refreshCounter != refreshCompareValue
			|=> refreshCounter == $past(writeData);
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");
	property p_cmp_wr;
		compareWrite |=> refreshCompareValue == $past(writeData);
	endproperty
	a_cmp_wr: assert property (p_cmp_wr) else $error("compare write lost");
	property p_sby_pins;
		(softStandby && pseudoStaticEnable)[*2] |-> area3ChipSelectN && !readStrobeOe
			&& !upperWriteStrobeOe && !lowerWriteStrobeOe;
	endproperty
	a_sby_pins: assert property (p_sby_pins) else $error("standby pins wrong");
	property p_self_ref;
		(softStandby && selfRefreshSelect && pseudoStaticEnable)[*2] |-> !refreshStrobeN;
	endproperty
	a_self_ref: assert property (p_self_ref) else $error("self refresh strobe high");
	property p_no_self;
		(softStandby && !selfRefreshSelect)[*2] |-> refreshStrobeN;
	endproperty
	a_no_self: assert property (p_no_self) else $error("standby strobe low");
	property p_exit;
		$fell(softStandby) |-> ##[1:3] refreshStrobeN;
	endproperty
	a_exit: assert property (p_exit) else $error("strobe not restored");
	property p_sby_clr;
		softStandby[*3] |-> refreshCounter == 8'h00 && timerControlStatus[7:6] == 2'h0;
	endproperty
	a_sby_clr: assert property (p_sby_clr) else $error("standby clear missing");
	property p_mask;
		(!timerControlStatus[6])[*3] |-> !compareInterrupt;
	endproperty
	a_mask: assert property (p_mask) else $error("interrupt not masked");
	property p_released;
		busReleased[*8] |-> !refreshActive;
	endproperty
	a_released: assert property (p_released) else $error("refresh while released");
	property p_ext;
		extMasterReq[*8] |-> busGrant == PRIT_GRANT_EXT;
	endproperty
	a_ext: assert property (p_ext) else $error("external master not granted");
endmodule

// >>> tb/prit_refresh_timer_tb_top.sv
// Bench for the refresh timer core with a pseudo-static RAM model.
// Assumes the core and package compiled first.
`timescale 1ns/100ps
module prit_refresh_timer_tb_top
	import prit_pkg::*;
;
	logic       clk = 0, rst = 1, ce, hardStandby, softStandby, pseudoStaticEnable;
	logic       dynamicRamEnable, selfRefreshSelect, area3WaitEnable, waitRequest;
	logic       counterWrite, compareWrite, controlWrite, flagClear;
	logic       extMasterReq, dmaReq, cpuReq, busReleased;
	logic [7:0] writeData, refreshCounter, refreshCompareValue, timerControlStatus;
	logic [1:0] busGrant;
	logic       compareInterrupt, refreshActive, refreshStrobeN, area3ChipSelectN;
	logic       readStrobeOe, upperWriteStrobeOe, lowerWriteStrobeOe;
	int         err_count = 0, compares = 0, cycles = 0, refreshCount, pulseLen, n0, i;
	prit_refresh_timer dut (.clk, .rst, .ce, .softStandby, .hardStandby,
		.pseudoStaticEnable, .dynamicRamEnable, .selfRefreshSelect, .area3WaitEnable,
		.waitRequest, .counterWrite, .compareWrite, .controlWrite, .writeData, .flagClear,
		.extMasterReq, .dmaReq, .cpuReq, .busReleased, .refreshCounter,
		.refreshCompareValue, .timerControlStatus, .compareInterrupt, .busGrant,
		.refreshActive, .refreshStrobeN, .area3ChipSelectN, .readStrobeOe,
		.upperWriteStrobeOe, .lowerWriteStrobeOe);
	prit_psram_model mem (.clk, .rst, .refreshStrobeN, .area3ChipSelectN,
		.refreshCount, .pulseLen);
	always #20 clk = ~clk;
	task automatic give_verdict;
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input int kind, input logic [7:0] d);
		writeData = d;
		counterWrite = (kind == 0);
		compareWrite = (kind == 1);
		controlWrite = (kind == 2);
		cyc(1);
		{counterWrite, compareWrite, controlWrite} = 3'h0;
		cyc(1);
	endtask
	task automatic wait_flag;
		for (i = 0; i < 300 && timerControlStatus[7] !== 1'b1; i++) cyc(1);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		{ce, hardStandby, waitRequest, area3WaitEnable} = 4'h8;
		{softStandby, pseudoStaticEnable, dynamicRamEnable, selfRefreshSelect} = 4'h0;
		{counterWrite, compareWrite, controlWrite, flagClear} = 4'h0;
		{extMasterReq, dmaReq, cpuReq, busReleased} = 4'h0;
		writeData = 8'h00;
		cyc(5);
		rst = 0;
		chk("counter", 8'h00, refreshCounter);
		chk("compare", 8'hFF, refreshCompareValue);
		chk("status", 8'h00, timerControlStatus);
		chk("grant", {6'h0, PRIT_GRANT_CPU}, {6'h0, busGrant});
		wr(1, 8'h03);
		chk("compare", 8'h03, refreshCompareValue);
		wr(0, 8'h01);
		chk("counter", 8'h01, refreshCounter);
		wr(2, 8'h48);
		for (i = 0; i < 100 && refreshCounter !== 8'h03; i++) cyc(1);
		chk("flag", 8'h00, {7'h0, timerControlStatus[7]});
		for (i = 0; i < 100 && refreshCounter === 8'h03; i++) cyc(1);
		chk("counter", 8'h00, refreshCounter);
		cyc(2);
		chk("flag", 8'h01, {7'h0, timerControlStatus[7]});
		chk("irq", 8'h01, {7'h0, compareInterrupt});
		flagClear = 1;
		cyc(1);
		flagClear = 0;
		wr(2, 8'h08);
		wait_flag();
		cyc(2);
		chk("irq", 8'h00, {7'h0, compareInterrupt});
		wr(2, 8'h48);
		// No bus request pending while standby is entered
		{pseudoStaticEnable, selfRefreshSelect, softStandby} = 3'h7;
		cyc(4);
		chk("counter", 8'h00, refreshCounter);
		chk("status", 8'h08, timerControlStatus);
		chk("compare", 8'h03, refreshCompareValue);
		chk("pins", 8'h01, {6'h0, refreshStrobeN, area3ChipSelectN});
		chk("float", 8'h00, {5'h0, readStrobeOe, upperWriteStrobeOe, lowerWriteStrobeOe});
		softStandby = 0;
		cyc(4);
		chk("strobe", 8'h01, {7'h0, refreshStrobeN});
		chk("drive", 8'h07, {5'h0, readStrobeOe, upperWriteStrobeOe, lowerWriteStrobeOe});
		n0 = refreshCount;
		wait_flag();
		cyc(8);
		chk("skipped", n0[7:0], refreshCount[7:0]);
		for (i = 0; i < 100 && refreshCount == n0; i++) cyc(1);
		chk("pulse", {5'h0, REFRESH_STATES}, pulseLen[7:0]);
		n0 = refreshCounter;
		hardStandby = 1;
		cyc(10);
		chk("halted", n0[7:0], refreshCounter);
		hardStandby = 0;
		wr(1, 8'h20);
		cyc(8);
		n0 = refreshCount;
		{busReleased, extMasterReq, dmaReq, cpuReq} = 4'hF;
		cyc(300);
		chk("released", n0[7:0], refreshCount[7:0]);
		chk("active", 8'h00, {7'h0, refreshActive});
		{busReleased, extMasterReq} = 2'h0;
		cyc(12);
		chk("held", n0[7:0] + 8'h01, refreshCount[7:0]);
		chk("grant", {6'h0, PRIT_GRANT_DMA}, {6'h0, busGrant});
		dmaReq = 0;
		cyc(3);
		chk("grant", {6'h0, PRIT_GRANT_CPU}, {6'h0, busGrant});
		give_verdict();
	end
endmodule
bind prit_refresh_timer prit_refresh_timer_monitor mon (.clk, .rst, .softStandby, .pseudoStaticEnable,
	.selfRefreshSelect, .counterWrite, .compareWrite, .writeData, .extMasterReq,
	.busReleased, .refreshCounter, .refreshCompareValue, .timerControlStatus,
	.compareInterrupt, .busGrant, .refreshActive, .refreshStrobeN, .area3ChipSelectN,
	.readStrobeOe, .upperWriteStrobeOe, .lowerWriteStrobeOe);
